//--- vgc_pkg.sv
// shared constants and types for the video gain control register bank
package vgc_pkg;
	// clock and tracking time constants
	localparam int CLK_HZ = 20000000;
	localparam real TC_SLOW_S = 2.0;
	localparam real TC_MEDIUM_S = 1.0;
	localparam real TC_FAST_S = 0.2;
	localparam int TC_SLOW_CYC = int'(TC_SLOW_S * CLK_HZ);
	localparam int TC_MEDIUM_CYC = int'(TC_MEDIUM_S * CLK_HZ);
	localparam int TC_FAST_CYC = int'(TC_FAST_S * CLK_HZ);
	localparam int CNT_W = 26;

	// bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_GAIN_MODE = 6'h2C;
	localparam logic [5:0] IDX_CHROMA_HI = 6'h2D;
	localparam logic [5:0] IDX_CHROMA_LO = 6'h2E;
	localparam logic [5:0] IDX_LUMA_HI = 6'h2F;
	localparam logic [5:0] IDX_LUMA_LO = 6'h30;
	localparam logic [5:0] IDX_SHADOW_HI = 6'h31;
	localparam logic [5:0] IDX_SHADOW_LO = 6'h32;
	localparam logic [5:0] IDX_MISC = 6'h33;

	// field positions
	localparam int GAIN_HI_LSB = 0;
	localparam int TIMING_LSB = 6;
	localparam int SURV_BIT = 7;
	localparam int PW_BIT = 0;
	localparam int AVL_BIT = 1;
	localparam int MAX_IRE_SELECT_LSB = 2;
	localparam int CKE_BIT = 6;
	localparam int CMODE_LSB = 0;
	localparam int LMODE_LSB = 4;

	// reserved bits read back as ones
	localparam logic [7:0] RSV_GAIN_HI = 8'h30;
	localparam logic [7:0] RSV_SHADOW_HI = 8'h70;
	localparam logic [7:0] RSV_MISC = 8'hA0;
	localparam logic [7:0] RSV_MODE = 8'h8C;

	// average brightness line window
	localparam logic [8:0] AVG_FIRST_LINE = 9'h021;
	localparam logic [8:0] AVG_LAST_LONG = 9'h136;
	localparam logic [8:0] AVG_LAST_SHORT = 9'h10E;

	// max input IRE per selection, entry 0 is the rightmost
	localparam logic [7:0][7:0] IRE_PAL_TAB = {8'h64, 8'h64, 8'h69, 8'h6E, 8'h73, 8'h78, 8'h7D, 8'h85};
	localparam logic [7:0][7:0] IRE_NTSC_TAB = {8'h64, 8'h64, 8'h64, 8'h64, 8'h69, 8'h6E, 8'h73, 8'h7A};

	typedef enum logic [1:0] {CM_MANUAL = 2'h0, CM_LUMA = 2'h1, CM_AUTO = 2'h2, CM_FREEZE = 2'h3} vgc_cmode_t;
	typedef enum logic [2:0] {
		LM_MANUAL = 3'h0, LM_AGC1 = 3'h1, LM_AGC2 = 3'h2, LM_AGC3 = 3'h3,
		LM_AGC4 = 3'h4, LM_PEAK = 3'h5, LM_AVG = 3'h6, LM_FREEZE = 3'h7
	} vgc_lmode_t;
	typedef enum logic [1:0] {TM_SLOW = 2'h0, TM_MEDIUM = 2'h1, TM_FAST = 2'h2, TM_QUALITY = 2'h3} vgc_timing_t;
	// gray order along idle -> half taken -> response
	typedef enum logic [1:0] {WS_IDLE = 2'h0, WS_HAVE_ADDR = 2'h1, WS_RESP = 2'h3, WS_HAVE_DATA = 2'h2} vgc_wstate_t;
endpackage

//--- vgc_regs.sv
// video gain control register bank with AXI4-Lite slave
// Function
// - chroma manual gain is 12 bits: hi nibble in reg 0x2D bits 3:0, low byte 0x2E.
// - chroma gain field is programmed gain or readback of applied gain per chroma mode.
// - chroma timing bits 7:6: slow 2 s, medium 1 s, fast 0.2 s, quality-dependent.
// - chroma timing acts only in chroma automatic burst mode.
// - luma manual gain 12 bits in 0x2F/0x30; programmed or applied readback per luma mode.
// - luma timing bits 7:6: slow 2 s, medium 1 s, fast 0.2 s, quality-dependent.
// - luma timing acts only in luma modes 001 through 100.
// - luma gain store takes effect only in luma manual fixed gain mode.
// - reading the luma gain store returns applied gain, depending on luma mode.
// - shadow hi bit 7 enables surveillance update from the luma gain store.
// - shadow lo holds store low byte; shadow hi bits 3:0 hold upper nibble.
// - misc bit 0 selects gain update once per line or once per field.
// - misc bit 1 selects average brightness lines 33-310 or 33-270.
// - misc bits 4:2 select max input IRE per standard from a table.
// - misc bit 6 enables colour kill.
// - chroma mode: manual, reuse luma gain, automatic from burst, frozen.
// - luma mode: manual, automatic 001-100, white peak, average video, frozen.
`timescale 1ns/1ps
module vgc_regs #(
	parameter int TC_SLOW_CYC = vgc_pkg::TC_SLOW_CYC,
	parameter int TC_MEDIUM_CYC = vgc_pkg::TC_MEDIUM_CYC,
	parameter int TC_FAST_CYC = vgc_pkg::TC_FAST_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [vgc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [vgc_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [vgc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [vgc_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [11:0] luma_gain_measured,
	input wire logic [11:0] chroma_gain_measured,
	input wire logic video_quality_indication,
	input wire logic line_strobe,
	input wire logic field_strobe,
	output logic [11:0] luma_gain_applied,
	output logic [11:0] chroma_gain_applied,
	output logic luma_agc_tick,
	output logic chroma_agc_tick,
	output logic luma_gain_update,
	output logic [8:0] avg_last_line,
	output logic [7:0] max_ire_pal,
	output logic [7:0] max_ire_ntsc,
	output logic colour_kill_enable
);
	typedef logic [vgc_pkg::CNT_W-1:0] vgc_cnt_t;

	typedef struct packed {
		vgc_pkg::vgc_wstate_t ws;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic [5:0] wa_idx;
		logic [7:0] wdata;
		logic wstrb0;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		vgc_pkg::vgc_cmode_t chroma_gain_mode;
		vgc_pkg::vgc_lmode_t luma_gain_mode;
		logic [1:0] chroma_agc_timing;
		logic [11:0] chroma_manual_gain;
		logic [1:0] luma_agc_timing;
		logic [11:0] luma_manual_gain;
		logic surveillance_update_enable;
		logic [11:0] luma_gain_store;
		logic peak_white_update_rate;
		logic average_brightness_lines;
		logic [2:0] max_ire_select;
		logic colour_kill;
		logic [11:0] luma_applied;
		logic [11:0] chroma_applied;
		vgc_cnt_t c_cnt;
		vgc_cnt_t l_cnt;
		logic c_tick;
		logic l_tick;
		logic l_update;
		logic [8:0] avg_last;
		logic [7:0] ire_pal;
		logic [7:0] ire_ntsc;
	} vgc_state_t;

	vgc_state_t s_r;
	vgc_state_t s_nxt;

	// only the eight words of this bank answer OKAY
	function automatic logic is_mapped(input logic [5:0] idx);
		is_mapped = (idx >= vgc_pkg::IDX_GAIN_MODE) && (idx <= vgc_pkg::IDX_MISC);
	endfunction

	// one tracking step per time constant; quality code picks fast on good video
	function automatic vgc_cnt_t tc_period(input logic [1:0] code, input logic good);
		case (code)
			vgc_pkg::TM_SLOW: tc_period = vgc_cnt_t'(TC_SLOW_CYC);
			vgc_pkg::TM_MEDIUM: tc_period = vgc_cnt_t'(TC_MEDIUM_CYC);
			vgc_pkg::TM_FAST: tc_period = vgc_cnt_t'(TC_FAST_CYC);
			default: tc_period = good ? vgc_cnt_t'(TC_FAST_CYC) : vgc_cnt_t'(TC_SLOW_CYC);
		endcase
	endfunction

	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic do_write;
	logic [5:0] idx_c;
	logic [7:0] data_c;
	logic strb_c;
	logic [5:0] ar_idx;
	logic luma_manual_mode;
	logic luma_auto_mode;
	vgc_cnt_t c_per;
	vgc_cnt_t l_per;

	always_comb begin
		s_nxt = s_r;
		aw_fire = awvalid && s_r.awready;
		w_fire = wvalid && s_r.wready;
		ar_fire = arvalid && s_r.arready;
		idx_c = aw_fire ? awaddr[7:2] : s_r.wa_idx;
		data_c = w_fire ? wdata[7:0] : s_r.wdata;
		strb_c = w_fire ? wstrb[0] : s_r.wstrb0;
		ar_idx = araddr[7:2];
		luma_manual_mode = (s_r.luma_gain_mode == vgc_pkg::LM_MANUAL);
		luma_auto_mode = (s_r.luma_gain_mode >= vgc_pkg::LM_AGC1) && (s_r.luma_gain_mode <= vgc_pkg::LM_AGC4);
		c_per = tc_period(s_r.chroma_agc_timing, video_quality_indication);
		l_per = tc_period(s_r.luma_agc_timing, video_quality_indication);
		do_write = 1'b0;

		// write channel: address and data accepted in either order
		if (aw_fire) begin
			s_nxt.wa_idx = awaddr[7:2];
		end
		if (w_fire) begin
			s_nxt.wdata = wdata[7:0];
			s_nxt.wstrb0 = wstrb[0];
		end
		case (s_r.ws)
			vgc_pkg::WS_IDLE: begin
				if (aw_fire && w_fire) begin
					do_write = 1'b1;
				end else if (aw_fire) begin
					s_nxt.ws = vgc_pkg::WS_HAVE_ADDR;
				end else if (w_fire) begin
					s_nxt.ws = vgc_pkg::WS_HAVE_DATA;
				end
			end
			vgc_pkg::WS_HAVE_ADDR: do_write = w_fire;
			vgc_pkg::WS_HAVE_DATA: do_write = aw_fire;
			vgc_pkg::WS_RESP: begin
				if (bready) begin
					s_nxt.ws = vgc_pkg::WS_IDLE;
					s_nxt.bvalid = 1'b0;
				end
			end
			default: s_nxt.ws = vgc_pkg::WS_IDLE;
		endcase
		if (do_write) begin
			s_nxt.ws = vgc_pkg::WS_RESP;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = is_mapped(idx_c) ? vgc_pkg::RESP_OKAY : vgc_pkg::RESP_SLVERR;
		end
		s_nxt.awready = (s_nxt.ws == vgc_pkg::WS_IDLE) || (s_nxt.ws == vgc_pkg::WS_HAVE_DATA);
		s_nxt.wready = (s_nxt.ws == vgc_pkg::WS_IDLE) || (s_nxt.ws == vgc_pkg::WS_HAVE_ADDR);

		// register stores; reserved bits are not stored, they read back as ones
		if (do_write && strb_c) begin
			case (idx_c)
				vgc_pkg::IDX_GAIN_MODE: begin
					s_nxt.chroma_gain_mode = vgc_pkg::vgc_cmode_t'(data_c[vgc_pkg::CMODE_LSB +: 2]);
					s_nxt.luma_gain_mode = vgc_pkg::vgc_lmode_t'(data_c[vgc_pkg::LMODE_LSB +: 3]);
				end
				vgc_pkg::IDX_CHROMA_HI: begin
					s_nxt.chroma_manual_gain[11:8] = data_c[vgc_pkg::GAIN_HI_LSB +: 4];
					s_nxt.chroma_agc_timing = data_c[vgc_pkg::TIMING_LSB +: 2];
				end
				vgc_pkg::IDX_CHROMA_LO: s_nxt.chroma_manual_gain[7:0] = data_c;
				vgc_pkg::IDX_LUMA_HI: begin
					s_nxt.luma_manual_gain[11:8] = data_c[vgc_pkg::GAIN_HI_LSB +: 4];
					s_nxt.luma_agc_timing = data_c[vgc_pkg::TIMING_LSB +: 2];
				end
				vgc_pkg::IDX_LUMA_LO: s_nxt.luma_manual_gain[7:0] = data_c;
				vgc_pkg::IDX_SHADOW_HI: begin
					s_nxt.luma_gain_store[11:8] = data_c[vgc_pkg::GAIN_HI_LSB +: 4];
					s_nxt.surveillance_update_enable = data_c[vgc_pkg::SURV_BIT];
				end
				vgc_pkg::IDX_SHADOW_LO: s_nxt.luma_gain_store[7:0] = data_c;
				vgc_pkg::IDX_MISC: begin
					s_nxt.peak_white_update_rate = data_c[vgc_pkg::PW_BIT];
					s_nxt.average_brightness_lines = data_c[vgc_pkg::AVL_BIT];
					s_nxt.max_ire_select = data_c[vgc_pkg::MAX_IRE_SELECT_LSB +: 3];
					s_nxt.colour_kill = data_c[vgc_pkg::CKE_BIT];
				end
				default: s_nxt.wa_idx = idx_c;
			endcase
		end

		// read channel: one outstanding read, data from the cycle it is taken
		if (ar_fire) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = is_mapped(ar_idx) ? vgc_pkg::RESP_OKAY : vgc_pkg::RESP_SLVERR;
			case (ar_idx)
				vgc_pkg::IDX_GAIN_MODE: s_nxt.rdata = vgc_pkg::RSV_MODE
					| {1'b0, s_r.luma_gain_mode, 2'h0, s_r.chroma_gain_mode};
				vgc_pkg::IDX_CHROMA_HI: s_nxt.rdata = vgc_pkg::RSV_GAIN_HI
					| {s_r.chroma_agc_timing, 2'h0, s_r.chroma_applied[11:8]};
				vgc_pkg::IDX_CHROMA_LO: s_nxt.rdata = s_r.chroma_applied[7:0];
				vgc_pkg::IDX_LUMA_HI: s_nxt.rdata = vgc_pkg::RSV_GAIN_HI
					| {s_r.luma_agc_timing, 2'h0, (luma_manual_mode ? s_r.luma_manual_gain[11:8]
					: s_r.luma_applied[11:8])};
				vgc_pkg::IDX_LUMA_LO: s_nxt.rdata = luma_manual_mode ? s_r.luma_manual_gain[7:0]
					: s_r.luma_applied[7:0];
				vgc_pkg::IDX_SHADOW_HI: s_nxt.rdata = vgc_pkg::RSV_SHADOW_HI
					| {s_r.surveillance_update_enable, 3'h0, (luma_manual_mode ? s_r.luma_gain_store[11:8]
					: s_r.luma_applied[11:8])};
				vgc_pkg::IDX_SHADOW_LO: s_nxt.rdata = luma_manual_mode ? s_r.luma_gain_store[7:0]
					: s_r.luma_applied[7:0];
				vgc_pkg::IDX_MISC: s_nxt.rdata = vgc_pkg::RSV_MISC
					| {1'b0, s_r.colour_kill, 1'b0, s_r.max_ire_select,
					s_r.average_brightness_lines, s_r.peak_white_update_rate};
				default: s_nxt.rdata = 8'h00;
			endcase
		end else if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end else if (!s_r.rvalid) begin
			s_nxt.arready = 1'b1;
		end

		// chroma gain actually applied
		case (s_r.chroma_gain_mode)
			vgc_pkg::CM_MANUAL: s_nxt.chroma_applied = s_r.chroma_manual_gain;
			vgc_pkg::CM_LUMA: s_nxt.chroma_applied = s_r.luma_applied;
			vgc_pkg::CM_AUTO: s_nxt.chroma_applied = chroma_gain_measured;
			default: s_nxt.chroma_applied = s_r.chroma_applied;
		endcase

		// luma gain actually applied; the store wins over manual gain when surveillance is on
		case (s_r.luma_gain_mode)
			vgc_pkg::LM_MANUAL: s_nxt.luma_applied = s_r.surveillance_update_enable
				? s_r.luma_gain_store : s_r.luma_manual_gain;
			vgc_pkg::LM_FREEZE: s_nxt.luma_applied = s_r.luma_applied;
			default: s_nxt.luma_applied = luma_gain_measured;
		endcase

		// tracking step pulses; a disabled loop sits reloaded so the first step is a full period
		s_nxt.c_tick = 1'b0;
		if (s_r.chroma_gain_mode != vgc_pkg::CM_AUTO) begin
			s_nxt.c_cnt = c_per - 1'b1;
		end else if (s_r.c_cnt == '0) begin
			s_nxt.c_cnt = c_per - 1'b1;
			s_nxt.c_tick = 1'b1;
		end else begin
			s_nxt.c_cnt = s_r.c_cnt - 1'b1;
		end
		s_nxt.l_tick = 1'b0;
		if (!luma_auto_mode) begin
			s_nxt.l_cnt = l_per - 1'b1;
		end else if (s_r.l_cnt == '0) begin
			s_nxt.l_cnt = l_per - 1'b1;
			s_nxt.l_tick = 1'b1;
		end else begin
			s_nxt.l_cnt = s_r.l_cnt - 1'b1;
		end

		// gain update rate only matters in peak white or average video modes
		s_nxt.l_update = ((s_r.luma_gain_mode == vgc_pkg::LM_PEAK) || (s_r.luma_gain_mode == vgc_pkg::LM_AVG))
			&& (s_r.peak_white_update_rate ? field_strobe : line_strobe);

		s_nxt.avg_last = s_r.average_brightness_lines ? vgc_pkg::AVG_LAST_SHORT : vgc_pkg::AVG_LAST_LONG;
		s_nxt.ire_pal = vgc_pkg::IRE_PAL_TAB[s_r.max_ire_select];
		s_nxt.ire_ntsc = vgc_pkg::IRE_NTSC_TAB[s_r.max_ire_select];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rresp = s_r.rresp;
	assign rdata = {24'h000000, s_r.rdata};
	assign luma_gain_applied = s_r.luma_applied;
	assign chroma_gain_applied = s_r.chroma_applied;
	assign luma_agc_tick = s_r.l_tick;
	assign chroma_agc_tick = s_r.c_tick;
	assign luma_gain_update = s_r.l_update;
	assign avg_last_line = s_r.avg_last;
	assign max_ire_pal = s_r.ire_pal;
	assign max_ire_ntsc = s_r.ire_ntsc;
	assign colour_kill_enable = s_r.colour_kill;

	default clocking vgc_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chroma_manual_gain_a: assert property (
		(s_r.chroma_gain_mode == vgc_pkg::CM_MANUAL) |=> (chroma_gain_applied == $past(s_r.chroma_manual_gain)))
		else $error("chroma gain not taken from manual value");
	chroma_timing_gate_a: assert property (
		(s_r.chroma_gain_mode != vgc_pkg::CM_AUTO) |=> !chroma_agc_tick)
		else $error("chroma tracking step outside burst mode");
	luma_timing_gate_a: assert property (
		(s_r.luma_gain_mode == vgc_pkg::LM_MANUAL || s_r.luma_gain_mode >= vgc_pkg::LM_PEAK) |=> !luma_agc_tick)
		else $error("luma tracking step outside automatic modes");
	luma_store_apply_a: assert property (
		(s_r.luma_gain_mode == vgc_pkg::LM_MANUAL && s_r.surveillance_update_enable)
		|=> (luma_gain_applied == $past(s_r.luma_gain_store)))
		else $error("luma store not applied in manual mode");
	store_readback_a: assert property (
		(arvalid && arready && araddr[7:2] == vgc_pkg::IDX_SHADOW_LO && s_r.luma_gain_mode != vgc_pkg::LM_MANUAL)
		|=> (rvalid && rdata[7:0] == $past(luma_gain_applied[7:0])))
		else $error("store readback is not the applied gain");
	colour_kill_wr_a: assert property (
		($rose(bvalid) && s_r.wa_idx == vgc_pkg::IDX_MISC && s_r.wstrb0) |-> (colour_kill_enable == s_r.wdata[6]))
		else $error("colour kill bit not stored");
	avg_lines_a: assert property (
		s_r.average_brightness_lines ##1 s_r.average_brightness_lines |-> (avg_last_line == vgc_pkg::AVG_LAST_SHORT))
		else $error("average line window wrong");
	max_ire_a: assert property (
		(s_r.max_ire_select == 3'h0) |=> (max_ire_pal == vgc_pkg::IRE_PAL_TAB[0] && max_ire_ntsc == 8'h7A))
		else $error("max IRE table wrong for selection zero");
	pw_update_a: assert property (
		(s_r.luma_gain_mode == vgc_pkg::LM_PEAK && line_strobe && !field_strobe)
		|=> (luma_gain_update == !$past(s_r.peak_white_update_rate)))
		else $error("gain update rate wrong");
	bresp_hold_a: assert property (
		(bvalid && !bready) |=> (bvalid && $stable(bresp)))
		else $error("write response dropped before taken");
	rdata_hold_a: assert property (
		(rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
		else $error("read data dropped before taken");
	luma_freeze_a: assert property (
		(s_r.luma_gain_mode == vgc_pkg::LM_FREEZE) |=> $stable(luma_gain_applied))
		else $error("luma gain moved while frozen");
	chroma_freeze_a: assert property (
		(s_r.chroma_gain_mode == vgc_pkg::CM_FREEZE) |=> $stable(chroma_gain_applied))
		else $error("chroma gain moved while frozen");
	avg_lines_long_a: assert property (
		!s_r.average_brightness_lines |=> (avg_last_line == vgc_pkg::AVG_LAST_LONG))
		else $error("long average line window wrong");

	write_seen_c: cover property (awvalid && awready && wvalid && wready ##[1:3] bvalid && bready);
	read_seen_c: cover property (arvalid && arready ##1 rvalid && rready);
	chroma_step_c: cover property (s_r.chroma_gain_mode == vgc_pkg::CM_AUTO ##1 chroma_agc_tick);
	luma_step_c: cover property (luma_agc_tick);
	gain_update_c: cover property (luma_gain_update);
endmodule

//--- video_gain_control_regs_tb.sv
// self-checking testbench for the video gain control register bank
`timescale 1ns/1ps
module video_gain_control_regs_tb;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr, rd, max_ire_pal, max_ire_ntsc;
	logic [31:0] wdata, rdata, rnd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [11:0] luma_gain_measured, chroma_gain_measured, luma_gain_applied, chroma_gain_applied, g, s;
	logic video_quality_indication, line_strobe, field_strobe, u;
	logic luma_agc_tick, chroma_agc_tick, luma_gain_update, colour_kill_enable;
	logic [8:0] avg_last_line;
	logic [2:0] lm;
	int err_count, compares, cycles, seed, gp, nl, nc;
	vgc_regs #(.TC_SLOW_CYC(40), .TC_MEDIUM_CYC(20), .TC_FAST_CYC(4)) i_dut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .luma_gain_measured, .chroma_gain_measured, .video_quality_indication,
		.line_strobe, .field_strobe, .luma_gain_applied, .chroma_gain_applied, .luma_agc_tick, .chroma_agc_tick,
		.luma_gain_update, .avg_last_line, .max_ire_pal, .max_ire_ntsc, .colour_kill_enable);
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic finish_test();
		if (err_count == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// long enough for every tick measurement, far below a hang
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			$display("[ERR] %0t timeout", $time);
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd_reg(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata[7:0];
		r = rresp;
		chk({8'h00, rdata[31:8]}, 32'h0);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wchk(input logic [5:0] idx, input logic [7:0] d);
		wr(idx, d, rsp);
		chk(rsp, vgc_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
	endtask
	task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
		rd_reg(idx, rd, rsp);
		chk(rd, exp);
		chk(rsp, vgc_pkg::RESP_OKAY);
	endtask
	// reserved bits 7,3,2 always written as ones
	task automatic mode(input logic [2:0] l, input logic [1:0] c);
		wchk(vgc_pkg::IDX_GAIN_MODE, {1'b1, l, 2'h3, c});
	endtask
	// first pass lands on a tick, second measures the spacing
	task automatic tick_gap(input bit c, output int n);
		repeat (2) begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (!(c ? chroma_agc_tick : luma_agc_tick) && n < 100);
		end
	endtask
	task automatic pulse(input bit fld, output logic up);
		line_strobe <= !fld;
		field_strobe <= fld;
		@(posedge aclk);
		line_strobe <= 1'b0;
		field_strobe <= 1'b0;
		@(posedge aclk);
		up = luma_gain_update;
		@(posedge aclk);
	endtask
	function automatic logic [7:0] ire_exp(input logic [2:0] sel, input bit pal);
		logic [7:0] tp [8];
		logic [7:0] tn [8];
		tp = '{8'h85, 8'h7D, 8'h78, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64};
		tn = '{8'h7A, 8'h73, 8'h6E, 8'h69, 8'h64, 8'h64, 8'h64, 8'h64};
		return pal ? tp[sel] : tn[sel];
	endfunction
	function automatic int per_exp(input int code, input bit q);
		return code == 0 ? 40 : code == 1 ? 20 : code == 2 ? 4 : (q ? 4 : 40);
	endfunction
	initial begin
		seed = 32'hac70;
		{err_count, compares, cycles} = '0;
		{aresetn, awvalid, wvalid, bready, arvalid, rready, line_strobe, field_strobe} = '0;
		{awaddr, araddr, wdata, luma_gain_measured, chroma_gain_measured, video_quality_indication} = '0;
		wstrb = 4'hF;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(avg_last_line, 9'h136);
		chk({max_ire_pal, max_ire_ntsc}, 16'h857A);
		rchk(vgc_pkg::IDX_CHROMA_HI, 8'h30);
		rchk(vgc_pkg::IDX_SHADOW_HI, 8'h70);
		rchk(vgc_pkg::IDX_MISC, 8'hA0);
		for (int i = 0; i < 8; i++) begin
			rnd = $random(seed);
			wchk(vgc_pkg::IDX_MISC, {1'b1, rnd[0], 1'b1, i[2:0], rnd[1], rnd[2]});
			chk({max_ire_pal, max_ire_ntsc}, {ire_exp(i[2:0], 1'b1), ire_exp(i[2:0], 1'b0)});
			chk(avg_last_line, rnd[1] ? 9'h10E : 9'h136);
			chk(colour_kill_enable, rnd[0]);
			rchk(vgc_pkg::IDX_MISC, {1'b1, rnd[0], 1'b1, i[2:0], rnd[1], rnd[2]});
		end
		mode(3'h0, 2'h0);
		for (int k = 0; k < 2; k++) begin
			g = 12'($random(seed));
			wchk(k ? vgc_pkg::IDX_LUMA_HI : vgc_pkg::IDX_CHROMA_HI, {2'h2, 2'h3, g[11:8]});
			wchk(k ? vgc_pkg::IDX_LUMA_LO : vgc_pkg::IDX_CHROMA_LO, g[7:0]);
			chk(k ? luma_gain_applied : chroma_gain_applied, g);
			rchk(k ? vgc_pkg::IDX_LUMA_HI : vgc_pkg::IDX_CHROMA_HI, {2'h2, 2'h3, g[11:8]});
			rchk(k ? vgc_pkg::IDX_LUMA_LO : vgc_pkg::IDX_CHROMA_LO, g[7:0]);
		end
		mode(3'h0, 2'h1);
		chk(chroma_gain_applied, g);
		s = 12'($random(seed));
		wchk(vgc_pkg::IDX_SHADOW_HI, {1'b1, 3'h7, s[11:8]});
		wchk(vgc_pkg::IDX_SHADOW_LO, s[7:0]);
		chk(luma_gain_applied, s);
		rchk(vgc_pkg::IDX_SHADOW_LO, s[7:0]);
		wchk(vgc_pkg::IDX_SHADOW_HI, {1'b0, 3'h7, s[11:8]});
		chk(luma_gain_applied, g);
		luma_gain_measured <= 12'($random(seed));
		chroma_gain_measured <= 12'($random(seed));
		mode(3'h1, 2'h2);
		chk(luma_gain_applied, luma_gain_measured);
		chk(chroma_gain_applied, chroma_gain_measured);
		rchk(vgc_pkg::IDX_LUMA_LO, luma_gain_measured[7:0]);
		rchk(vgc_pkg::IDX_SHADOW_LO, luma_gain_measured[7:0]);
		rchk(vgc_pkg::IDX_CHROMA_LO, chroma_gain_measured[7:0]);
		g = luma_gain_measured;
		s = chroma_gain_measured;
		mode(3'h7, 2'h3);
		luma_gain_measured <= ~g;
		chroma_gain_measured <= ~s;
		repeat (3) @(posedge aclk);
		chk({luma_gain_applied, chroma_gain_applied}, {g, s});
		mode(3'h1, 2'h2);
		for (int k = 0; k < 2; k++) begin
			for (int j = 0; j < 5; j++) begin
				video_quality_indication <= (j == 3);
				wchk(k ? vgc_pkg::IDX_LUMA_HI : vgc_pkg::IDX_CHROMA_HI, {j > 3 ? 2'h3 : j[1:0], 2'h3, 4'h0});
				tick_gap(k == 0, gp);
				chk(gp, per_exp(j > 3 ? 3 : j, j == 3));
			end
		end
		wchk(vgc_pkg::IDX_LUMA_HI, 8'hB0);
		for (int i = 1; i < 5; i++) begin
			mode(i[2:0], 2'h0);
			tick_gap(1'b0, gp);
			chk(gp, 4);
		end
		for (int k = 0; k < 2; k++) begin
			mode(k ? 3'h7 : 3'h5, k ? 2'h3 : 2'h0);
			{nl, nc} = '0;
			repeat (60) begin
				@(posedge aclk);
				nl += luma_agc_tick;
				nc += chroma_agc_tick;
			end
			chk(nl, 0);
			chk(nc, 0);
		end
		for (int p = 0; p < 6; p++) begin
			lm = p < 2 ? 3'h1 : p < 4 ? 3'h5 : 3'h6;
			mode(lm, 2'h0);
			wchk(vgc_pkg::IDX_MISC, {7'h50, p[0]});
			for (int f = 0; f < 2; f++) begin
				pulse(f[0], u);
				chk(u, lm != 3'h1 && f == p[0]);
			end
		end
		wr(6'h00, 8'hFF, rsp);
		chk(rsp, vgc_pkg::RESP_SLVERR);
		rd_reg(6'h3F, rd, rsp);
		chk(rsp, vgc_pkg::RESP_SLVERR);
		rchk(vgc_pkg::IDX_MISC, 8'hA1);
		finish_test();
	end
endmodule
